// >>> shared/laser_cmd_pkg.sv
// Constants, opcodes and state type of the laser output command core.
// Assumes a parser outside that delivers decoded commands with integer parameters.
package laser_cmd_pkg;
   // ----------------------------------------
   // Timing
   // ----------------------------------------
   localparam int CLK_HZ      = 200_000_000;
   localparam int ARM_TIME_MS = 2000;
   localparam int ARM_CYCLES  = ARM_TIME_MS * (CLK_HZ / 1000);
   localparam int ARM_W       = 29;
   // ----------------------------------------
   // Limits and table
   // ----------------------------------------
   localparam logic [15:0] ABS_MAX_MA = 16'h1f40;
   localparam logic [5:0]  CAL_LAST   = 6'h31;
   localparam int          CAL_WORDS  = 100;
   localparam int          DIV_BITS   = 30;
   localparam int          FRAC_BITS  = 8;
   localparam int          MSG_LEN    = 8;
   // ----------------------------------------
   // Command codes on cmd_op_i
   // ----------------------------------------
   localparam logic [3:0] OP_NOP  = 4'h0;
   localparam logic [3:0] OP_ID   = 4'h1;
   localparam logic [3:0] OP_OUT  = 4'h2;
   localparam logic [3:0] OP_CUR  = 4'h3;
   localparam logic [3:0] OP_MAXC = 4'h4;
   localparam logic [3:0] OP_POW  = 4'h5;
   localparam logic [3:0] OP_MAXP = 4'h6;
   localparam logic [3:0] OP_CAL  = 4'h7;
   // ----------------------------------------
   // Output states and characters
   // ----------------------------------------
   localparam logic [1:0] OUT_OFF    = 2'h0;
   localparam logic [1:0] OUT_ARMED  = 2'h1;
   localparam logic [1:0] OUT_ACTIVE = 2'h2;
   localparam logic [7:0] CH_R  = 8'h52;
   localparam logic [7:0] CH_E  = 8'h65;
   localparam logic [7:0] CH_RR = 8'h72;
   localparam logic [7:0] CH_Q  = 8'h3f;
   localparam logic [7:0] CH_0  = 8'h30;
   localparam logic [7:0] CH_A  = 8'h41;
   localparam logic [7:0] CH_CR = 8'h0d;
   localparam logic [7:0] CH_LF = 8'h0a;

   typedef enum logic [2:0] {
      ST_IDLE, ST_EXEC, ST_DIV, ST_INTERP, ST_DEC, ST_CR, ST_LF, ST_EMIT
   } core_state_t;
endpackage

// >>> src/laser_output_command_core.sv
// Command execution core: decoded host commands in, ASCII acknowledge bytes out.
// Assumes a framing parser on sys_clk_i and a byte transmitter with valid/ready.
//
// Functional notes
// - No-op command answers with R and CR LF only.
// - Identity query takes no parameters, answers own address as two hex characters.
// - Output state holds 0 disabled, 1 enabled, 2 active emission.
// - Going 1 to 2 refused until two seconds after entering 1.
// - Changes 1 to 0, 2 to 0, 2 to 1 are immediate.
// - Output command without parameter reports present state.
// - A fault on fault_i forces output state to 0 by itself.
// - Output state is 0 after reset.
// - Current command picks channel, optional mA sets, else reports stored current.
// - Current above channel maximum current answers with error.
// - Current and power setpoints are zero after reset.
// - Each channel stores maximum current, set or reported like current.
// - Maximum current above absolute rating answers with error.
// - Power command picks channel, optional mW sets, else reports stored power.
// - Power above channel maximum power answers with error.
// - Setting power updates reported current; setting current leaves power.
// - Every answer starts with R and ends with CR LF.
// - Recognised command with bad parameters answers Rerr.
// - Power converts to current through 50-entry table with linear interpolation.
`timescale 1ns/1ps
module laser_output_command_core #(
   parameter int ARM_CYCLES = laser_cmd_pkg::ARM_CYCLES
) (
   input  wire logic        sys_clk_i,
   input  wire logic        rstn_i,
   input  wire logic [7:0]  own_id_i,
   input  wire logic        fault_i,
   input  wire logic        cmd_valid_i,
   input  wire logic [7:0]  cmd_addr_i,
   input  wire logic        cmd_known_i,
   input  wire logic [3:0]  cmd_op_i,
   input  wire logic [1:0]  cmd_nparam_i,
   input  wire logic [15:0] cmd_p0_i,
   input  wire logic [15:0] cmd_p1_i,
   input  wire logic [15:0] cmd_p2_i,
   input  wire logic        tx_ready_i,
   output logic             tx_valid_o,
   output logic [7:0]       tx_data_o,
   output logic             busy_o,
   output logic [1:0]       out_state_o,
   output logic             emit_en_o,
   output logic [15:0]      cur_set0_o,
   output logic [15:0]      cur_set1_o
);
   // ----------------------------------------
   // Elaboration check
   // ----------------------------------------
   if (ARM_CYCLES < 1 || ARM_CYCLES >= 2 ** laser_cmd_pkg::ARM_W) begin : g_bad_arm
      $error("ARM_CYCLES out of range");
   end

   // ----------------------------------------
   // Functions
   // ----------------------------------------
   function automatic logic [7:0] hex_char(input logic [3:0] n);
      hex_char = (n < 4'ha) ? laser_cmd_pkg::CH_0 + {4'h0, n}
                            : laser_cmd_pkg::CH_A + {4'h0, n - 4'ha};
   endfunction

   function automatic logic [15:0] pow10(input logic [2:0] d);
      case (d)
         3'h0:    pow10 = 16'h2710;
         3'h1:    pow10 = 16'h03e8;
         3'h2:    pow10 = 16'h0064;
         3'h3:    pow10 = 16'h000a;
         default: pow10 = 16'h0001;
      endcase
   endfunction

   function automatic logic [6:0] cal_addr(input logic ch, input logic [5:0] step);
      cal_addr = ch ? 7'h32 + {1'b0, step} : {1'b0, step};
   endfunction

   // ----------------------------------------
   // Storage
   // ----------------------------------------
   laser_cmd_pkg::core_state_t state_reg;
   logic [7:0]  id_s1_reg, id_s2_reg;
   logic        fault_s1_reg, fault_s2_reg;
   logic        known_reg;
   logic [3:0]  op_reg;
   logic [1:0]  np_reg;
   logic [15:0] p0_reg, p1_reg, p2_reg;
   logic [1:0]  out_reg;
   logic [laser_cmd_pkg::ARM_W-1:0] arm_cnt_reg;
   logic [15:0] cur_reg  [2];
   logic [15:0] maxc_reg [2];
   logic [15:0] pow_reg  [2];
   logic [15:0] maxp_reg [2];
   logic [15:0] cal_mem  [laser_cmd_pkg::CAL_WORDS];
   logic [7:0]  msg_reg  [laser_cmd_pkg::MSG_LEN];
   logic [3:0]  len_reg, pos_reg;
   logic [15:0] val_reg;
   logic [3:0]  dig_reg;
   logic [2:0]  dpos_reg;
   logic        lead_reg;
   logic [laser_cmd_pkg::DIV_BITS-1:0] quo_reg;
   logic [16:0] rem_reg;
   logic [4:0]  dcnt_reg;
   logic        tx_valid_reg;
   logic [7:0]  tx_data_reg;
   logic        busy_reg;
   // Registered twin of state 2 so the enable pin comes straight from a flop
   logic        emit_reg;

   // ----------------------------------------
   // Command decode
   // ----------------------------------------
   wire        addr_hit = (cmd_addr_i == id_s2_reg) || (cmd_addr_i == 8'h00);
   wire        ch       = p0_reg[0];
   wire        ch_ok    = p0_reg <= 16'h0001;
   wire        is_query = np_reg == 2'h1;
   wire        is_set   = np_reg == 2'h2;
   wire        armed    = arm_cnt_reg == laser_cmd_pkg::ARM_W'(ARM_CYCLES);
   wire [6:0]  cal_wr_a = cal_addr(ch, p1_reg[5:0]);
   wire        step_ok  = p1_reg <= {10'h000, laser_cmd_pkg::CAL_LAST};

   // Target 1 from anywhere, 2 only from 2 or an armed 1, never while faulted
   wire out_to_ok = (p0_reg == {14'h0, laser_cmd_pkg::OUT_OFF})
      || (!fault_s2_reg && p0_reg == {14'h0, laser_cmd_pkg::OUT_ARMED})
      || (!fault_s2_reg && p0_reg == {14'h0, laser_cmd_pkg::OUT_ACTIVE}
          && (out_reg == laser_cmd_pkg::OUT_ACTIVE
              || (out_reg == laser_cmd_pkg::OUT_ARMED && armed)));
   wire chan_np_ok = (is_query || is_set) && ch_ok;

   logic        exec_err;
   logic        exec_val;
   logic [15:0] exec_q;
   always_comb begin
      exec_err = 1'b0;
      exec_val = 1'b0;
      exec_q   = 16'h0000;
      case (op_reg)
         laser_cmd_pkg::OP_NOP: exec_err = np_reg != 2'h0;
         laser_cmd_pkg::OP_ID:  exec_err = np_reg != 2'h0;
         laser_cmd_pkg::OP_OUT: begin
            exec_err = np_reg > 2'h1 || (np_reg == 2'h1 && !out_to_ok);
            exec_val = np_reg == 2'h0;
            exec_q   = {14'h0, out_reg};
         end
         laser_cmd_pkg::OP_CUR: begin
            exec_err = !chan_np_ok || (is_set && p1_reg > maxc_reg[ch]);
            exec_val = is_query;
            exec_q   = cur_reg[ch];
         end
         laser_cmd_pkg::OP_MAXC: begin
            exec_err = !chan_np_ok || (is_set && p1_reg > laser_cmd_pkg::ABS_MAX_MA);
            exec_val = is_query;
            exec_q   = maxc_reg[ch];
         end
         laser_cmd_pkg::OP_POW: begin
            exec_err = !chan_np_ok || (is_set && p1_reg > maxp_reg[ch]);
            exec_val = is_query;
            exec_q   = pow_reg[ch];
         end
         laser_cmd_pkg::OP_MAXP: begin
            exec_err = !chan_np_ok;
            exec_val = is_query;
            exec_q   = maxp_reg[ch];
         end
         laser_cmd_pkg::OP_CAL: begin
            exec_err = np_reg < 2'h2 || !ch_ok || !step_ok;
            exec_val = np_reg == 2'h2;
            exec_q   = cal_mem[cal_wr_a];
         end
         default: exec_err = 1'b1;
      endcase
   end

   // ----------------------------------------
   // Power to current
   // ----------------------------------------
   // Scaled position 49*256*p/pmax: integer part is the step, low byte the fraction
   wire [laser_cmd_pkg::DIV_BITS-1:0] div_num =
      laser_cmd_pkg::DIV_BITS'(p1_reg) * laser_cmd_pkg::DIV_BITS'(16'h3100);
   wire [16:0] rem_sh   = {rem_reg[15:0], quo_reg[laser_cmd_pkg::DIV_BITS-1]};
   wire        rem_ge   = rem_sh >= {1'b0, maxp_reg[ch]};
   wire [5:0]  idx      = quo_reg[13:8];
   wire [6:0]  lo_a     = cal_addr(ch, idx);
   wire [6:0]  hi_a     = cal_addr(ch, (idx >= laser_cmd_pkg::CAL_LAST) ? idx : idx + 6'h01);
   wire [15:0] lo_v     = cal_mem[lo_a];
   wire signed [16:0] diff = $signed({1'b0, cal_mem[hi_a]}) - $signed({1'b0, lo_v});
   wire signed [25:0] prod = diff * $signed({1'b0, quo_reg[7:0]});
   wire signed [17:0] interp = $signed({2'b00, lo_v}) + prod[25:8];
   wire [15:0] pw       = pow10(dpos_reg);

   // ----------------------------------------
   // Sequencer
   // ----------------------------------------
   always_ff @(posedge sys_clk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         state_reg    <= laser_cmd_pkg::ST_IDLE;
         id_s1_reg    <= 8'h00;
         id_s2_reg    <= 8'h00;
         fault_s1_reg <= 1'b0;
         fault_s2_reg <= 1'b0;
         known_reg    <= 1'b0;
         op_reg       <= 4'h0;
         np_reg       <= 2'h0;
         p0_reg       <= 16'h0000;
         p1_reg       <= 16'h0000;
         p2_reg       <= 16'h0000;
         out_reg      <= laser_cmd_pkg::OUT_OFF;
         emit_reg     <= 1'b0;
         arm_cnt_reg  <= '0;
         for (int i = 0; i < 2; i++) begin
            cur_reg[i]  <= 16'h0000;
            pow_reg[i]  <= 16'h0000;
            maxc_reg[i] <= 16'h0000;
            maxp_reg[i] <= 16'h0000;
         end
         for (int i = 0; i < laser_cmd_pkg::MSG_LEN; i++) begin
            msg_reg[i] <= 8'h00;
         end
         len_reg      <= 4'h0;
         pos_reg      <= 4'h0;
         val_reg      <= 16'h0000;
         dig_reg      <= 4'h0;
         dpos_reg     <= 3'h0;
         lead_reg     <= 1'b0;
         quo_reg      <= '0;
         rem_reg      <= 17'h00000;
         dcnt_reg     <= 5'h00;
         tx_valid_reg <= 1'b0;
         tx_data_reg  <= 8'h00;
         busy_reg     <= 1'b0;
      end else begin
         id_s1_reg    <= own_id_i;
         id_s2_reg    <= id_s1_reg;
         fault_s1_reg <= fault_i;
         fault_s2_reg <= fault_s1_reg;
         // Arming timer restarts on every entry to 1, whether from 0 or from 2
         if (out_reg != laser_cmd_pkg::OUT_ARMED) begin
            arm_cnt_reg <= '0;
         end else if (!armed) begin
            arm_cnt_reg <= arm_cnt_reg + 1'b1;
         end
         if (fault_s2_reg) begin
            out_reg  <= laser_cmd_pkg::OUT_OFF;
            emit_reg <= 1'b0;
         end
         case (state_reg)
            laser_cmd_pkg::ST_IDLE: begin
               if (cmd_valid_i && addr_hit) begin
                  known_reg <= cmd_known_i;
                  op_reg    <= cmd_op_i;
                  np_reg    <= cmd_nparam_i;
                  p0_reg    <= cmd_p0_i;
                  p1_reg    <= cmd_p1_i;
                  p2_reg    <= cmd_p2_i;
                  busy_reg  <= 1'b1;
                  state_reg <= laser_cmd_pkg::ST_EXEC;
               end
            end
            laser_cmd_pkg::ST_EXEC: begin
               msg_reg[0] <= laser_cmd_pkg::CH_R;
               len_reg    <= 4'h1;
               state_reg  <= laser_cmd_pkg::ST_CR;
               if (!known_reg) begin
                  msg_reg[1] <= laser_cmd_pkg::CH_Q;
                  msg_reg[2] <= laser_cmd_pkg::CH_Q;
                  msg_reg[3] <= laser_cmd_pkg::CH_Q;
                  len_reg    <= 4'h4;
               end else if (exec_err) begin
                  msg_reg[1] <= laser_cmd_pkg::CH_E;
                  msg_reg[2] <= laser_cmd_pkg::CH_RR;
                  msg_reg[3] <= laser_cmd_pkg::CH_RR;
                  len_reg    <= 4'h4;
               end else if (exec_val) begin
                  val_reg   <= exec_q;
                  dig_reg   <= 4'h0;
                  dpos_reg  <= 3'h0;
                  lead_reg  <= 1'b0;
                  state_reg <= laser_cmd_pkg::ST_DEC;
               end else begin
                  case (op_reg)
                     laser_cmd_pkg::OP_ID: begin
                        msg_reg[1] <= hex_char(id_s2_reg[7:4]);
                        msg_reg[2] <= hex_char(id_s2_reg[3:0]);
                        len_reg    <= 4'h3;
                     end
                     laser_cmd_pkg::OP_OUT: begin
                        out_reg  <= p0_reg[1:0];
                        emit_reg <= p0_reg[1:0] == laser_cmd_pkg::OUT_ACTIVE;
                     end
                     laser_cmd_pkg::OP_CUR:  cur_reg[ch] <= p1_reg;
                     laser_cmd_pkg::OP_MAXC: maxc_reg[ch] <= p1_reg;
                     laser_cmd_pkg::OP_MAXP: maxp_reg[ch] <= p1_reg;
                     laser_cmd_pkg::OP_CAL:  cal_mem[cal_wr_a] <= p2_reg;
                     laser_cmd_pkg::OP_POW: begin
                        pow_reg[ch] <= p1_reg;
                        quo_reg     <= (maxp_reg[ch] == 16'h0000) ? '0 : div_num;
                        rem_reg     <= 17'h00000;
                        dcnt_reg    <= 5'h00;
                        state_reg   <= (maxp_reg[ch] == 16'h0000) ? laser_cmd_pkg::ST_INTERP
                                                                  : laser_cmd_pkg::ST_DIV;
                     end
                     default: ;
                  endcase
               end
            end
            laser_cmd_pkg::ST_DIV: begin
               rem_reg  <= rem_ge ? rem_sh - {1'b0, maxp_reg[ch]} : rem_sh;
               quo_reg  <= {quo_reg[laser_cmd_pkg::DIV_BITS-2:0], rem_ge};
               dcnt_reg <= dcnt_reg + 5'h01;
               if (dcnt_reg == 5'(laser_cmd_pkg::DIV_BITS - 1)) begin
                  state_reg <= laser_cmd_pkg::ST_INTERP;
               end
            end
            laser_cmd_pkg::ST_INTERP: begin
               cur_reg[ch] <= interp[15:0];
               state_reg   <= laser_cmd_pkg::ST_CR;
            end
            laser_cmd_pkg::ST_DEC: begin
               if (val_reg >= pw) begin
                  val_reg <= val_reg - pw;
                  dig_reg <= dig_reg + 4'h1;
               end else begin
                  // Leading zeros dropped, a lone zero still printed
                  if (dig_reg != 4'h0 || lead_reg || dpos_reg == 3'h4) begin
                     msg_reg[len_reg[2:0]] <= laser_cmd_pkg::CH_0 + {4'h0, dig_reg};
                     len_reg               <= len_reg + 4'h1;
                     lead_reg              <= 1'b1;
                  end
                  dig_reg  <= 4'h0;
                  dpos_reg <= dpos_reg + 3'h1;
                  if (dpos_reg == 3'h4) begin
                     state_reg <= laser_cmd_pkg::ST_CR;
                  end
               end
            end
            laser_cmd_pkg::ST_CR: begin
               msg_reg[len_reg[2:0]] <= laser_cmd_pkg::CH_CR;
               len_reg               <= len_reg + 4'h1;
               state_reg             <= laser_cmd_pkg::ST_LF;
            end
            laser_cmd_pkg::ST_LF: begin
               msg_reg[len_reg[2:0]] <= laser_cmd_pkg::CH_LF;
               len_reg               <= len_reg + 4'h1;
               pos_reg               <= 4'h0;
               state_reg             <= laser_cmd_pkg::ST_EMIT;
            end
            laser_cmd_pkg::ST_EMIT: begin
               if (!tx_valid_reg || tx_ready_i) begin
                  if (pos_reg == len_reg) begin
                     tx_valid_reg <= 1'b0;
                     busy_reg     <= 1'b0;
                     state_reg    <= laser_cmd_pkg::ST_IDLE;
                  end else begin
                     tx_valid_reg <= 1'b1;
                     tx_data_reg  <= msg_reg[pos_reg[2:0]];
                     pos_reg      <= pos_reg + 4'h1;
                  end
               end
            end
            default: state_reg <= laser_cmd_pkg::ST_IDLE;
         endcase
      end
   end

   // ----------------------------------------
   // Outputs
   // ----------------------------------------
   assign tx_valid_o  = tx_valid_reg;
   assign tx_data_o   = tx_data_reg;
   assign busy_o      = busy_reg;
   assign out_state_o = out_reg;
   assign emit_en_o   = emit_reg;
   assign cur_set0_o  = cur_reg[0];
   assign cur_set1_o  = cur_reg[1];
endmodule

// >>> bench/laser_cmd_asserts.sv
// Port-level checks for the laser output command core.
// Assumes one clock and a bind onto the core's ports.
`timescale 1ns/1ps
module laser_cmd_asserts #(
   parameter int ARM_CYCLES = 20
) (
   input wire logic       sys_clk_i,
   input wire logic       rstn_i,
   input wire logic       fault_i,
   input wire logic       cmd_valid_i,
   input wire logic [7:0] cmd_addr_i,
   input wire logic       cmd_known_i,
   input wire logic [3:0] cmd_op_i,
   input wire logic [1:0] cmd_nparam_i,
   input wire logic       tx_ready_i,
   input wire logic       tx_valid_o,
   input wire logic [7:0] tx_data_o,
   input wire logic       busy_o,
   input wire logic [1:0] out_state_o,
   input wire logic       emit_en_o
);
   // ----------------------------------------
   // Helpers and checks
   // ----------------------------------------
   int   arm_cnt;
   logic first_pend;
   wire  take = cmd_valid_i && !busy_o && (cmd_addr_i == 8'h00);
   default clocking cb @(posedge sys_clk_i); endclocking
   default disable iff (!rstn_i);
   // Sampled cycles spent in state 1; the core arms only after the full count
   always_ff @(posedge sys_clk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         arm_cnt    <= 0;
         first_pend <= 1'b0;
      end else begin
         arm_cnt    <= (out_state_o == laser_cmd_pkg::OUT_ARMED) ? arm_cnt + 1 : 0;
         first_pend <= $rose(busy_o) | (first_pend & !(tx_valid_o & tx_ready_i));
      end
   end
   AST_EMIT: assert property (
      emit_en_o == (out_state_o == laser_cmd_pkg::OUT_ACTIVE)) else $error("emit mismatch");
   AST_NO_3: assert property (
      out_state_o != 2'h3) else $error("illegal output state");
   AST_FAULT: assert property (
      fault_i [*4] |-> out_state_o == laser_cmd_pkg::OUT_OFF) else $error("fault not obeyed");
   AST_NO_SKIP: assert property (
      $past(out_state_o) == laser_cmd_pkg::OUT_OFF |-> out_state_o != laser_cmd_pkg::OUT_ACTIVE)
      else $error("went 0 to 2");
   AST_ARM: assert property (
      $past(out_state_o) == laser_cmd_pkg::OUT_ARMED && emit_en_o |-> arm_cnt >= ARM_CYCLES)
      else $error("activated before arming delay");
   AST_TX_HOLD: assert property (
      tx_valid_o && !tx_ready_i |=> tx_valid_o && $stable(tx_data_o)) else $error("byte dropped");
   AST_NOP: assert property (
      take && cmd_known_i && cmd_op_i == laser_cmd_pkg::OP_NOP && cmd_nparam_i == 2'h0
      |-> ##5 tx_valid_o && tx_data_o == laser_cmd_pkg::CH_R) else $error("no-op answer late");
   AST_FIRST_R: assert property (
      first_pend && tx_valid_o |-> tx_data_o == laser_cmd_pkg::CH_R) else $error("no leading R");
   AST_END: assert property (
      tx_valid_o && tx_ready_i && tx_data_o == laser_cmd_pkg::CH_LF |=> !tx_valid_o && !busy_o)
      else $error("line end not final");
   COV_NOP: cover property (take && cmd_op_i == laser_cmd_pkg::OP_NOP);
   COV_EMIT: cover property ($rose(emit_en_o));
   COV_FAULT: cover property (fault_i && out_state_o != laser_cmd_pkg::OUT_OFF);
endmodule
bind laser_output_command_core laser_cmd_asserts #(.ARM_CYCLES(ARM_CYCLES)) laser_cmd_asserts_inst (
   .sys_clk_i(sys_clk_i), .rstn_i(rstn_i), .fault_i(fault_i), .cmd_valid_i(cmd_valid_i),
   .cmd_addr_i(cmd_addr_i), .cmd_known_i(cmd_known_i), .cmd_op_i(cmd_op_i),
   .cmd_nparam_i(cmd_nparam_i), .tx_ready_i(tx_ready_i), .tx_valid_o(tx_valid_o),
   .tx_data_o(tx_data_o), .busy_o(busy_o), .out_state_o(out_state_o), .emit_en_o(emit_en_o));

// >>> bench/tx_sink.sv
// Byte sink standing in for the host-side transmitter.
// Assumes the core's valid/ready byte port on the same clock.
`timescale 1ns/1ps
module tx_sink (
   input  wire logic       sys_clk_i,
   input  wire logic       rstn_i,
   input  wire logic       slow_i,
   input  wire logic       tx_valid_i,
   input  wire logic [7:0] tx_data_i,
   output logic            tx_ready_o,
   output logic [63:0]     line_o,
   output logic            crlf_o
);
   // ----------------------------------------
   // Pacing and line capture
   // ----------------------------------------
   logic [1:0] pace_reg;
   logic       cr_seen_reg;
   wire        take = tx_valid_i & tx_ready_o;
   // Slow mode accepts one cycle in four to exercise holding
   assign tx_ready_o = !slow_i | (pace_reg == 2'h0);
   always_ff @(posedge sys_clk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         pace_reg    <= 2'h0;
         cr_seen_reg <= 1'b0;
         line_o      <= 64'h0;
         crlf_o      <= 1'b0;
      end else begin
         pace_reg <= pace_reg + 2'h1;
         if (take) begin
            cr_seen_reg <= (tx_data_i == 8'h0d);
            if (tx_data_i == 8'h52) begin
               line_o <= 64'h52;
               crlf_o <= 1'b0;
            end else if (tx_data_i == 8'h0a) begin
               crlf_o <= cr_seen_reg;
            end else if (tx_data_i != 8'h0d) begin
               line_o <= {line_o[55:0], tx_data_i};
            end
         end
      end
   end
endmodule

// >>> bench/tb_laser_output_command_core.sv
// Self-checking bench for the laser output command core.
// Assumes the byte sink model and the bound checker.
`timescale 1ns/1ps
module tb_laser_output_command_core;
   // ----------------------------------------
   // Stimulus, tasks and tests
   // ----------------------------------------
   localparam int ARM = 20;
   typedef struct packed {
      logic [3:0]  op;
      logic [1:0]  np;
      logic [15:0] p0;
      logic [15:0] p1;
      logic [15:0] p2;
      logic [63:0] exp;
   } row_t;
   localparam int NROW = 33;
   row_t rows [NROW] = '{
      '{4'h0,2'h0,16'h0,16'h0,16'h0,"R"}, '{4'h0,2'h1,16'h0,16'h0,16'h0,"Rerr"},
      '{4'h1,2'h0,16'h0,16'h0,16'h0,"R0A"}, '{4'hf,2'h0,16'h0,16'h0,16'h0,"R???"},
      '{4'h2,2'h0,16'h0,16'h0,16'h0,"R0"}, '{4'h3,2'h1,16'h0,16'h0,16'h0,"R0"},
      '{4'h5,2'h1,16'h1,16'h0,16'h0,"R0"}, '{4'h3,2'h2,16'h0,16'h1,16'h0,"Rerr"},
      '{4'h4,2'h2,16'h0,16'h1f41,16'h0,"Rerr"}, '{4'h4,2'h2,16'h0,16'h1f40,16'h0,"R"},
      '{4'h4,2'h1,16'h0,16'h0,16'h0,"R8000"}, '{4'h3,2'h2,16'h0,16'h1f40,16'h0,"R"},
      '{4'h3,2'h2,16'h0,16'h1f41,16'h0,"Rerr"}, '{4'h3,2'h1,16'h0,16'h0,16'h0,"R8000"},
      '{4'h4,2'h2,16'h1,16'h3e8,16'h0,"R"}, '{4'h3,2'h2,16'h1,16'h1f4,16'h0,"R"},
      '{4'h5,2'h2,16'h1,16'h1,16'h0,"Rerr"}, '{4'h6,2'h2,16'h1,16'h64,16'h0,"R"},
      '{4'h5,2'h2,16'h1,16'h65,16'h0,"Rerr"}, '{4'h7,2'h3,16'h1,16'h31,16'h2bc,"R"},
      '{4'h7,2'h3,16'h1,16'h18,16'h64,"R"}, '{4'h7,2'h3,16'h1,16'h19,16'h12c,"R"},
      '{4'h5,2'h2,16'h1,16'h64,16'h0,"R"}, '{4'h3,2'h1,16'h1,16'h0,16'h0,"R700"},
      '{4'h5,2'h2,16'h1,16'h32,16'h0,"R"}, '{4'h3,2'h1,16'h1,16'h0,16'h0,"R200"},
      '{4'h3,2'h2,16'h1,16'h1f4,16'h0,"R"}, '{4'h5,2'h1,16'h1,16'h0,16'h0,"R50"},
      '{4'h2,2'h1,16'h2,16'h0,16'h0,"Rerr"}, '{4'h2,2'h1,16'h1,16'h0,16'h0,"R"},
      '{4'h2,2'h1,16'h2,16'h0,16'h0,"Rerr"}, '{4'h7,2'h2,16'h1,16'h19,16'h0,"R300"},
      '{4'h6,2'h1,16'h1,16'h0,16'h0,"R100"}};
   logic        sys_clk = 1'b0, rstn = 1'b0, fault = 1'b0, cmd_valid = 1'b0, slow = 1'b0;
   logic [7:0]  addr = 8'h00;
   logic [3:0]  op = 4'h0;
   logic [1:0]  np = 2'h0;
   logic [15:0] p0 = 16'h0, p1 = 16'h0, p2 = 16'h0;
   logic        tx_valid, tx_ready, busy, emit, crlf;
   logic [7:0]  tx_data;
   logic [1:0]  out_state;
   logic [15:0] cur0, cur1;
   logic [63:0] line;
   int          n_fail = 0, checked = 0;
   always #2.5 sys_clk = ~sys_clk;
   laser_output_command_core #(.ARM_CYCLES(ARM)) laser_output_command_core_inst (
      .sys_clk_i(sys_clk), .rstn_i(rstn), .own_id_i(8'h0a), .fault_i(fault),
      .cmd_valid_i(cmd_valid), .cmd_addr_i(addr), .cmd_known_i(op != 4'hf), .cmd_op_i(op),
      .cmd_nparam_i(np), .cmd_p0_i(p0), .cmd_p1_i(p1), .cmd_p2_i(p2), .tx_ready_i(tx_ready),
      .tx_valid_o(tx_valid), .tx_data_o(tx_data), .busy_o(busy), .out_state_o(out_state),
      .emit_en_o(emit), .cur_set0_o(cur0), .cur_set1_o(cur1));
   tx_sink tx_sink_inst (.sys_clk_i(sys_clk), .rstn_i(rstn), .slow_i(slow),
      .tx_valid_i(tx_valid), .tx_data_i(tx_data), .tx_ready_o(tx_ready), .line_o(line),
      .crlf_o(crlf));
   task automatic check(input logic [63:0] got, input logic [63:0] exp);
      checked++;
      if (got !== exp) begin
         n_fail++;
         $display("[ERR] t=%0t got %h exp %h", $time, got, exp);
      end
   endtask
   task automatic wrap_up();
      $display("checked %0d n_fail %0d", checked, n_fail);
      if (n_fail == 0 && checked > 0) begin
         $display("== PASSED ==");
      end else begin
         $display("== FAILED ==");
      end
      $finish;
   endtask
   // Waits for busy to drop; a dropped command never raises it
   task automatic send(input logic [7:0] a, input row_t r);
      int k;
      @(negedge sys_clk);
      {addr, op, np, p0, p1, p2} = {a, r.op, r.np, r.p0, r.p1, r.p2};
      cmd_valid = 1'b1;
      @(negedge sys_clk);
      cmd_valid = 1'b0;
      k = 0;
      while (busy !== 1'b0 && k < 400) begin
         @(negedge sys_clk);
         k++;
      end
      if (k >= 400) n_fail++;
      check(line, r.exp);
      check(64'(crlf), 64'h1);
   endtask
   initial begin
      #100000;
      n_fail++;
      wrap_up();
   end
   initial begin
      repeat (3) @(posedge sys_clk);
      check(64'(out_state), 64'h0);
      check(64'({cur0, cur1}), 64'h0);
      @(negedge sys_clk);
      rstn = 1'b1;
      repeat (3) @(negedge sys_clk);
      for (int i = 0; i < NROW; i++) begin
         slow = i[0];
         send(8'h00, rows[i]);
         $display("row %0d done", i);
      end
      check(64'(cur0), 64'h1f40);
      check(64'(cur1), 64'h1f4);
      repeat (ARM + 5) @(negedge sys_clk);
      send(8'h00, row_t'{4'h2,2'h1,16'h2,16'h0,16'h0,"R"});
      check(64'({out_state, emit}), 64'h5);
      send(8'h00, row_t'{4'h2,2'h0,16'h0,16'h0,16'h0,"R2"});
      send(8'h00, row_t'{4'h2,2'h1,16'h1,16'h0,16'h0,"R"});
      send(8'h00, row_t'{4'h2,2'h1,16'h2,16'h0,16'h0,"Rerr"});
      send(8'h00, row_t'{4'h2,2'h1,16'h0,16'h0,16'h0,"R"});
      $display("arming test done");
      // A request for another unit must leave the stale line R untouched
      send(8'h05, row_t'{4'h2,2'h0,16'h0,16'h0,16'h0,"R"});
      send(8'h0a, row_t'{4'h2,2'h0,16'h0,16'h0,16'h0,"R0"});
      $display("address test done");
      send(8'h00, row_t'{4'h2,2'h1,16'h1,16'h0,16'h0,"R"});
      fault = 1'b1;
      repeat (6) @(negedge sys_clk);
      check(64'(out_state), 64'h0);
      send(8'h00, row_t'{4'h2,2'h1,16'h1,16'h0,16'h0,"Rerr"});
      fault = 1'b0;
      $display("fault test done");
      @(negedge sys_clk);
      rstn = 1'b0;
      @(negedge sys_clk);
      check(64'({out_state, cur0, cur1}), 64'h0);
      rstn = 1'b1;
      repeat (3) @(negedge sys_clk);
      send(8'h00, row_t'{4'h3,2'h1,16'h1,16'h0,16'h0,"R0"});
      $display("reset test done");
      wrap_up();
   end
endmodule
